// ### logic/sbl_pkg.sv
// sbl_pkg: constants, error causes and carrier structs for the binary load/unload handler
// assumes: one 10 MHz system clock, bytes arrive already assembled by a uart
package sbl_pkg;
   localparam int unsigned CLK_HZ        = 10000000;        // system clock rate
   localparam int unsigned TIMEOUT_S     = 60;              // stage timeout in seconds
   localparam longint unsigned TIMEOUT_CYC = longint'(TIMEOUT_S) * longint'(CLK_HZ);
   localparam logic [7:0]  CHR_CR        = 8'h0D;           // carriage return
   localparam logic [7:0]  CHR_SPACE     = 8'h20;           // separator
   localparam logic [7:0]  CHR_RUBOUT    = 8'h7F;           // rubout
   localparam logic [7:0]  CHR_X         = 8'h58;           // command letter
   localparam logic [7:0]  CHR_CTRL_C    = 8'h03;           // interrupt
   localparam logic [7:0]  CHR_CTRL_S    = 8'h13;           // pause
   localparam logic [7:0]  CHR_CTRL_Q    = 8'h11;           // resume
   localparam logic [7:0]  CHR_CTRL_O    = 8'h0F;           // output suppression
   localparam logic [7:0]  CHR_PROMPT    = 8'h3E;           // '>' prompt char
   localparam logic [7:0]  CHR_QUERY     = 8'h3F;           // '?' error char
   localparam logic [1:0]  PROMPT_LEN    = 2'h3;            // three '>' chars
   localparam int unsigned DIR_BIT       = 31;              // direction bit of count
   localparam int unsigned LINE_MAX      = 32;              // command line buffer depth

   // error causes reported with the done pulse
   typedef enum logic [1:0] {
      SBL_ERR_NONE    = 2'b00,
      SBL_ERR_CMD     = 2'b01,
      SBL_ERR_DATA    = 2'b10,
      SBL_ERR_TIMEOUT = 2'b11
   } sbl_err_e;

   // memory request to the system
   typedef struct packed {
      logic        wr;     // 1 write, 0 read
      logic [31:0] addr;   // byte address
      logic [7:0]  data;   // write data
   } sbl_mem_req_s;

   // outcome of one command
   typedef struct packed {
      logic     done;      // one-cycle end of command
      sbl_err_e err;       // cause, none on success
   } sbl_result_s;
endpackage : sbl_pkg

// ### logic/sbl_top.sv
// sbl_top: binary load/unload console command engine
// assumes: rx bytes as one-cycle strobes from a uart on clk_in, tx byte ready/valid,
// one-byte memory port with request/acknowledge, console passes control only after X
`timescale 1ns/100ps
`default_nettype none
module sbl_top #(
   parameter longint unsigned TIMEOUT_CYC = sbl_pkg::TIMEOUT_CYC,  // sixty-second wait
   parameter int unsigned     CNT_W       = 31                     // byte count width
) (
   input  wire logic                 clk_in,        // system clock
   input  wire logic                 srst_in,       // synchronous reset, high
   input  wire logic                 ce_in,         // clock enable
   input  wire logic                 start_in,      // console hands line over (X seen)
   input  wire logic                 rx_valid_in,   // received byte strobe
   input  wire logic [7:0]           rx_data_in,    // received byte
   output logic                      echo_out,      // console may echo this rx byte
   output logic                      flow_en_out,   // console flow control active
   output logic                      tx_valid_out,  // transmit byte valid
   output logic [7:0]                tx_data_out,   // transmit byte
   input  wire logic                 tx_ready_in,   // transmitter takes byte
   output logic                      mem_req_out,   // memory request
   output sbl_pkg::sbl_mem_req_s     mem_out,       // memory request contents
   input  wire logic                 mem_ack_in,    // memory done
   input  wire logic [7:0]           mem_rdata_in,  // memory read data
   input  wire logic                 mem_err_in,    // memory error with ack
   input  wire logic                 line_err_in,   // framing or overrun with rx byte
   output logic                      busy_out,      // command in progress
   output sbl_pkg::sbl_result_s      result_out     // end of command and cause
);
   typedef enum logic [3:0] {
      SBL_IDLE    = 4'h0,
      SBL_LINE    = 4'h1,
      SBL_CKSUM   = 4'h2,
      SBL_PROMPT  = 4'h3,
      SBL_LDATA   = 4'h4,
      SBL_LWRITE  = 4'h5,
      SBL_LCKSUM  = 4'h6,
      SBL_UREAD   = 4'h7,
      SBL_USEND   = 4'h8,
      SBL_UCKSUM  = 4'h9,
      SBL_ERROR   = 4'hA,
      SBL_DONE    = 4'hB
   } sbl_state_e;

   sbl_state_e        state;
   logic [7:0]        line_buf [sbl_pkg::LINE_MAX];  // command line for rubout undo
   logic [5:0]        line_len;
   logic [7:0]        csum;          // 8-bit accumulator
   logic [31:0]       addr;
   logic [31:0]       count_word;
   logic [31:0]       num_acc;       // hex field being parsed
   logic              field;         // 0 address, 1 count
   logic [CNT_W-1:0]  remain;
   logic              is_unload;
   logic              bad;           // sticky load error
   logic [1:0]        prompt_n;
   logic [7:0]        ubyte;
   logic              paused;
   logic              suppress;
   logic [63:0]       tmo;
   logic              tmo_hit;
   logic [3:0]        hex_val;
   logic              hex_ok;
   logic [7:0]        undo_chr;
   sbl_pkg::sbl_err_e err_cause;
   logic              suppress_abort;  // interrupt seen during unload

   // hex digit decode of the received char
   always_comb begin
      hex_ok  = 1'b1;
      hex_val = 4'h0;
      if (rx_data_in >= 8'h30 && rx_data_in <= 8'h39) begin
         hex_val = 4'(rx_data_in - 8'h30);
      end else if (rx_data_in >= 8'h41 && rx_data_in <= 8'h46) begin
         hex_val = 4'(rx_data_in - 8'h37);
      end else if (rx_data_in >= 8'h61 && rx_data_in <= 8'h66) begin
         hex_val = 4'(rx_data_in - 8'h57);
      end else begin
         hex_ok = 1'b0;
      end
   end

   assign undo_chr = (line_len != 6'h00) ? line_buf[5'(line_len - 6'h01)] : 8'h00;
   assign tmo_hit  = (tmo >= TIMEOUT_CYC - 64'h1);
   assign suppress_abort = rx_valid_in && rx_data_in == sbl_pkg::CHR_CTRL_C;

   // main sequencer
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state     <= SBL_IDLE;
         line_len  <= 6'h00;
         csum      <= 8'h00;
         addr      <= 32'h0;
         count_word<= 32'h0;
         num_acc   <= 32'h0;
         field     <= 1'b0;
         remain    <= '0;
         is_unload <= 1'b0;
         bad       <= 1'b0;
         prompt_n  <= 2'h0;
         ubyte     <= 8'h00;
         err_cause <= sbl_pkg::SBL_ERR_NONE;
      end else if (ce_in) begin
         case (state)
            SBL_IDLE: begin
               if (start_in) begin
                  state     <= SBL_LINE;
                  line_len  <= 6'h00;
                  csum      <= sbl_pkg::CHR_X;  // command letter counts in the sum
                  num_acc   <= 32'h0;
                  field     <= 1'b0;
                  bad       <= 1'b0;
                  err_cause <= sbl_pkg::SBL_ERR_NONE;
               end
            end
            SBL_LINE: begin
               if (rx_valid_in) begin
                  if (rx_data_in == sbl_pkg::CHR_CR) begin
                     count_word <= num_acc;
                     state      <= SBL_CKSUM;
                  end else if (rx_data_in == sbl_pkg::CHR_RUBOUT) begin
                     if (line_len != 6'h00) begin
                        csum     <= csum - undo_chr;
                        line_len <= line_len - 6'h01;
                        if (undo_chr == sbl_pkg::CHR_SPACE) begin
                           field   <= 1'b0;
                           num_acc <= addr;
                        end else begin
                           num_acc <= num_acc >> 4;
                        end
                     end
                  end else if (line_len < 6'(sbl_pkg::LINE_MAX)) begin
                     csum     <= csum + rx_data_in;
                     line_buf[line_len[4:0]] <= rx_data_in;
                     line_len <= line_len + 6'h01;
                     if (rx_data_in == sbl_pkg::CHR_SPACE) begin
                        if (line_len != 6'h00 && !field) begin
                           addr    <= num_acc;
                           field   <= 1'b1;
                           num_acc <= 32'h0;
                        end
                     end else if (hex_ok) begin
                        num_acc <= {num_acc[27:0], hex_val};
                     end
                  end
               end
            end
            SBL_CKSUM: begin
               if (tmo_hit) begin
                  err_cause <= sbl_pkg::SBL_ERR_TIMEOUT;
                  state     <= SBL_ERROR;
               end else if (rx_valid_in) begin
                  if (8'(csum + rx_data_in) == 8'h00) begin
                     is_unload <= count_word[sbl_pkg::DIR_BIT];
                     remain    <= count_word[CNT_W-1:0];
                     prompt_n  <= 2'h0;
                     state     <= SBL_PROMPT;
                  end else begin
                     err_cause <= sbl_pkg::SBL_ERR_CMD;
                     state     <= SBL_ERROR;
                  end
                  csum <= 8'h00;
               end
            end
            SBL_PROMPT: begin
               if (tx_ready_in) begin
                  prompt_n <= prompt_n + 2'h1;
                  if (prompt_n == sbl_pkg::PROMPT_LEN - 2'h1) begin
                     if (is_unload) begin
                        state <= (remain == '0) ? SBL_UCKSUM : SBL_UREAD;
                     end else begin
                        state <= (remain == '0) ? SBL_LCKSUM : SBL_LDATA;
                     end
                  end
               end
            end
            SBL_LDATA: begin
               if (tmo_hit) begin
                  err_cause <= sbl_pkg::SBL_ERR_TIMEOUT;
                  state     <= SBL_ERROR;
               end else if (rx_valid_in) begin
                  csum  <= csum + rx_data_in;
                  ubyte <= rx_data_in;
                  if (line_err_in) begin
                     bad <= 1'b1;
                  end
                  state <= SBL_LWRITE;
               end
            end
            SBL_LWRITE: begin
               if (mem_ack_in) begin
                  if (mem_err_in) begin
                     bad <= 1'b1;
                  end
                  addr   <= addr + 32'h1;
                  remain <= remain - 1'b1;
                  state  <= (remain == CNT_W'(1)) ? SBL_LCKSUM : SBL_LDATA;
               end
            end
            SBL_LCKSUM: begin
               if (tmo_hit) begin
                  err_cause <= sbl_pkg::SBL_ERR_TIMEOUT;
                  state     <= SBL_ERROR;
               end else if (rx_valid_in) begin
                  if (bad || line_err_in || 8'(csum + rx_data_in) != 8'h00) begin
                     err_cause <= sbl_pkg::SBL_ERR_DATA;
                     state     <= SBL_ERROR;
                  end else begin
                     state <= SBL_DONE;
                  end
               end
            end
            SBL_UREAD: begin
               if (suppress_abort) begin
                  state <= SBL_DONE;
               end else if (mem_ack_in) begin
                  ubyte <= mem_rdata_in;
                  state <= SBL_USEND;
               end
            end
            SBL_USEND: begin
               if (suppress_abort) begin
                  state <= SBL_DONE;
               end else if (tx_ready_in && !paused) begin
                  csum   <= csum + ubyte;
                  addr   <= addr + 32'h1;
                  remain <= remain - 1'b1;
                  state  <= (remain == CNT_W'(1)) ? SBL_UCKSUM : SBL_UREAD;
               end
            end
            SBL_UCKSUM: begin
               if (suppress_abort) begin
                  state <= SBL_DONE;
               end else if (tx_ready_in && !paused) begin
                  state <= SBL_DONE;
               end
            end
            SBL_ERROR: begin
               if (tx_ready_in) begin
                  state <= SBL_DONE;
               end
            end
            SBL_DONE: begin
               state <= SBL_IDLE;
            end
            default: begin
               state <= SBL_IDLE;
            end
         endcase
      end
   end

   // control characters honoured only while unloading
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         paused   <= 1'b0;
         suppress <= 1'b0;
      end else if (ce_in) begin
         if (state == SBL_UREAD || state == SBL_USEND || state == SBL_UCKSUM) begin
            if (rx_valid_in && rx_data_in == sbl_pkg::CHR_CTRL_S) begin
               paused <= 1'b1;
            end else if (rx_valid_in && rx_data_in == sbl_pkg::CHR_CTRL_Q) begin
               paused <= 1'b0;
            end
            if (rx_valid_in && rx_data_in == sbl_pkg::CHR_CTRL_O) begin
               suppress <= ~suppress;
            end
         end else begin
            paused   <= 1'b0;
            suppress <= 1'b0;
         end
      end
   end

   // sixty-second stage timer, restarted by every received byte
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         tmo <= 64'h0;
      end else if (ce_in) begin
         if (rx_valid_in || !(state == SBL_CKSUM || state == SBL_LDATA || state == SBL_LCKSUM)) begin
            tmo <= 64'h0;
         end else if (!tmo_hit) begin
            tmo <= tmo + 64'h1;
         end
      end
   end

   // transmit path: prompt, unload data, unload checksum, error char
   always_comb begin
      tx_valid_out = 1'b0;
      tx_data_out  = 8'h00;
      case (state)
         SBL_PROMPT: begin
            tx_valid_out = 1'b1;
            tx_data_out  = sbl_pkg::CHR_PROMPT;
         end
         SBL_USEND: begin
            tx_valid_out = !paused && !suppress;
            tx_data_out  = ubyte;
         end
         SBL_UCKSUM: begin
            tx_valid_out = !paused && !suppress;
            tx_data_out  = 8'(8'h00 - csum);
         end
         SBL_ERROR: begin
            tx_valid_out = 1'b1;
            tx_data_out  = sbl_pkg::CHR_QUERY;
         end
         default: begin
            tx_valid_out = 1'b0;
         end
      endcase
   end

   // echo only while the command line is typed, flow control while idle and while it is typed
   assign echo_out    = (state == SBL_LINE);
   assign flow_en_out = (state == SBL_IDLE) || (state == SBL_LINE);

   // memory port, one byte per request
   assign mem_req_out  = (state == SBL_LWRITE) || (state == SBL_UREAD);
   assign mem_out.wr   = (state == SBL_LWRITE);
   assign mem_out.addr = addr;
   assign mem_out.data = ubyte;

   assign busy_out        = (state != SBL_IDLE);
   assign result_out.done = (state == SBL_DONE);
   assign result_out.err  = err_cause;
endmodule // sbl_top
`default_nettype wire

// ### test/sbl_top_assertions.sv
// sbl_top_assertions: port-level checks for the binary load/unload engine
// assumes: bound into sbl_top, one clock, ce_in held high by the bench
`timescale 1ns/100ps
`default_nettype none
module sbl_top_assertions #(
   parameter longint unsigned TIMEOUT_CYC = 200,  // stage wait
   parameter int unsigned     CNT_W       = 31    // count width
) (
   input wire logic                  clk_in,        // clock
   input wire logic                  srst_in,       // reset
   input wire logic                  ce_in,         // clock enable
   input wire logic                  start_in,      // start
   input wire logic                  rx_valid_in,   // rx strobe
   input wire logic [7:0]            rx_data_in,    // rx byte
   input wire logic                  echo_out,      // echo allowed
   input wire logic                  flow_en_out,   // flow control on
   input wire logic                  tx_valid_out,  // tx valid
   input wire logic [7:0]            tx_data_out,   // tx byte
   input wire logic                  tx_ready_in,   // tx ready
   input wire logic                  mem_req_out,   // memory request
   input wire sbl_pkg::sbl_mem_req_s mem_out,       // request contents
   input wire logic                  mem_ack_in,    // memory ack
   input wire logic [7:0]            mem_rdata_in,  // read data
   input wire logic                  mem_err_in,    // memory error
   input wire logic                  line_err_in,   // line error
   input wire logic                  busy_out,      // busy
   input wire sbl_pkg::sbl_result_s  result_out     // result
);
   logic        ck_wait;    // command checksum byte still due
   logic        seen_acc;   // a memory access done in this command
   logic [31:0] last_addr;  // address of that access

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // checksum stage tracking
   always_ff @(posedge clk_in) begin
      if (srst_in || flow_en_out) ck_wait <= 1'b1;
      else if (rx_valid_in) ck_wait <= 1'b0;
   end

   // last memory address of the running command
   always_ff @(posedge clk_in) begin
      if (srst_in || !busy_out) begin
         seen_acc  <= 1'b0;
         last_addr <= 32'h0;
      end else if (mem_req_out && mem_ack_in) begin
         seen_acc  <= 1'b1;
         last_addr <= mem_out.addr;
      end
   end

   sequence s_cksum_in;
      ck_wait && !flow_en_out && busy_out && rx_valid_in;
   endsequence
   sequence s_answer;
      tx_valid_out && (tx_data_out == sbl_pkg::CHR_PROMPT || tx_data_out == sbl_pkg::CHR_QUERY);
   endsequence

   property p_answer; s_cksum_in |=> s_answer; endproperty
   a_answer: assert property (p_answer) else $error("no answer to checksum");
   property p_flow_off; $fell(flow_en_out) |-> $past(rx_valid_in) && $past(rx_data_in) == sbl_pkg::CHR_CR; endproperty
   a_flow_off: assert property (p_flow_off) else $error("flow off without return");
   property p_tx_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
   property p_mem_hold; mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_out); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request changed");
   property p_done_pulse; result_out.done |=> !result_out.done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_idle_quiet; !busy_out |-> !tx_valid_out && !mem_req_out; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
   property p_echo_line; echo_out |-> flow_en_out && busy_out; endproperty
   a_echo_line: assert property (p_echo_line) else $error("echo off line");
   property p_mem_after_cr; mem_req_out |-> !flow_en_out && !echo_out; endproperty
   a_mem_after_cr: assert property (p_mem_after_cr) else $error("memory access too early");
   property p_addr_step; mem_req_out && seen_acc |-> mem_out.addr == last_addr + 32'h1; endproperty
   a_addr_step: assert property (p_addr_step) else $error("address not ascending");
endmodule // sbl_top_assertions

bind sbl_top sbl_top_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC), .CNT_W(CNT_W)) u_sbl_chk (.*);
`default_nettype wire

// ### test/sbl_sys_model.sv
// sbl_sys_model: memory and transmitter at the far side of the engine
// assumes: memory acks after ACK_DLY waits, transmitter ready every other cycle
`timescale 1ns/100ps
`default_nettype none
module sbl_sys_model #(
   parameter int ACK_DLY = 2  // wait cycles before ack
) (
   input  wire logic                  clk_in,         // clock
   input  wire logic                  srst_in,        // reset
   input  wire logic                  mem_req_in,     // memory request
   input  wire sbl_pkg::sbl_mem_req_s mem_in,         // request contents
   output logic                       mem_ack_out,    // ack pulse
   output logic [7:0]                 mem_rdata_out,  // read data
   output logic                       mem_err_out,    // error with ack
   input  wire logic                  tx_valid_in,    // tx valid
   input  wire logic [7:0]            tx_data_in,     // tx byte
   output logic                       tx_ready_out    // tx ready
);
   logic [7:0]  tx_q[$];       // bytes sent by the engine
   logic [31:0] wr_addr_q[$];  // write addresses seen
   logic [7:0]  wr_data_q[$];  // write data seen
   logic        err_arm = 1'b0;
   int          wait_cnt;

   // memory answers and transmitter logging
   always @(posedge clk_in) begin
      if (srst_in) begin
         mem_ack_out   <= 1'b0;
         mem_err_out   <= 1'b0;
         mem_rdata_out <= 8'h00;
         tx_ready_out  <= 1'b0;
         wait_cnt      <= 0;
      end else begin
         if (mem_req_in && !mem_ack_out && wait_cnt == ACK_DLY) begin
            mem_ack_out   <= 1'b1;
            mem_err_out   <= err_arm;
            wait_cnt      <= 0;
            mem_rdata_out <= mem_in.addr[7:0] ^ 8'hA5;
            if (mem_in.wr) begin
               wr_addr_q.push_back(mem_in.addr);
               wr_data_q.push_back(mem_in.data);
            end
         end else begin
            mem_ack_out   <= 1'b0;
            mem_err_out   <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;  // no stale data between acks
            if (mem_req_in && !mem_ack_out) wait_cnt <= wait_cnt + 1;
         end
         tx_ready_out <= ~tx_ready_out;  // stalls every other cycle
         if (tx_valid_in && tx_ready_out) tx_q.push_back(tx_data_in);
      end
   end
endmodule // sbl_sys_model
`default_nettype wire

// ### test/sbl_top_tb.sv
// sbl_top_tb: scenario bench for the binary load/unload engine
// assumes: the host is played by the bench, memory and transmitter by sbl_sys_model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module sbl_top_tb;
   localparam longint unsigned TMO = 200;  // shortened stage wait
   logic                 clk_in = 1'b0;
   logic                 srst_in, ce_in, start_in, rx_valid_in, line_err_in;
   logic [7:0]           rx_data_in;
   logic                 echo_out, flow_en_out, tx_valid_out, tx_ready_in, busy_out;
   logic [7:0]           tx_data_out, mem_rdata_in;
   logic                 mem_req_out, mem_ack_in, mem_err_in;
   sbl_pkg::sbl_mem_req_s mem_out;
   sbl_pkg::sbl_result_s  result_out;
   logic [7:0]           exp_q[$];
   int                   fails = 0, num_checks = 0, cyc_cnt = 0;

   sbl_top #(.TIMEOUT_CYC(TMO), .CNT_W(31)) dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
      .start_in(start_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .echo_out(echo_out),
      .flow_en_out(flow_en_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
      .tx_ready_in(tx_ready_in), .mem_req_out(mem_req_out), .mem_out(mem_out), .mem_ack_in(mem_ack_in),
      .mem_rdata_in(mem_rdata_in), .mem_err_in(mem_err_in), .line_err_in(line_err_in),
      .busy_out(busy_out), .result_out(result_out));
   sbl_sys_model #(.ACK_DLY(2)) u_sys (.clk_in(clk_in), .srst_in(srst_in), .mem_req_in(mem_req_out),
      .mem_in(mem_out), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in), .mem_err_out(mem_err_in),
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));

   // clock and hang guard
   always #50 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fails++;
         end_of_test();
      end
   end

   // load data with console control characters first, then a ramp
   function automatic logic [7:0] dval(input int i);
      logic [47:0] ctl;
      ctl = 48'h1311030F0D7F;
      return (i < 6) ? ctl[47-8*i -: 8] : 8'(i * 11);
   endfunction

   task automatic send(input logic [7:0] b, input logic echo_exp);
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("echo", echo_exp, echo_out)
      @(posedge clk_in);
      rx_valid_in <= 1'b1;
      rx_data_in  <= b;
      @(posedge clk_in);
      rx_valid_in <= 1'b0;
   endtask

   task automatic send_hex(input logic [31:0] v, inout logic [7:0] sum);
      logic       lead;
      logic [7:0] c;
      lead = 1'b1;
      for (int k = 7; k >= 0; k--) begin
         if (v[4*k +: 4] != 4'h0 || k == 0) lead = 1'b0;
         c = (v[4*k +: 4] < 4'hA) ? 8'h30 + v[4*k +: 4] : 8'h37 + v[4*k +: 4];
         if (!lead) begin
            sum = sum + c;
            send(c, 1'b1);
         end
      end
   endtask

   task automatic command(input logic [31:0] addr, cnt, input logic [7:0] adj, input int gap, input bit ck);
      logic [7:0] sum;
      u_sys.tx_q.delete();
      u_sys.wr_addr_q.delete();
      u_sys.wr_data_q.delete();
      exp_q.delete();
      @(posedge clk_in);
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      sum = sbl_pkg::CHR_X;
      send_hex(addr, sum);
      sum = sum + sbl_pkg::CHR_SPACE;
      send(sbl_pkg::CHR_SPACE, 1'b1);
      send_hex(cnt, sum);
      send(sbl_pkg::CHR_CR, 1'b1);
      repeat (gap) @(posedge clk_in);
      if (ck) send(8'h00 - sum + adj, 1'b0);
   endtask

   task automatic wait_done(output int cyc);
      logic got;
      got = 1'b0;
      for (cyc = 0; cyc < 4000 && !got; cyc++) begin
         @(negedge clk_in);
         got = (result_out.done === 1'b1);
      end
      `CHK("done", 1'b1, got)
   endtask

   task automatic chk_tx();
      `CHK("tx count", exp_q.size(), u_sys.tx_q.size())
      foreach (exp_q[i]) if (i < u_sys.tx_q.size()) `CHK("tx byte", exp_q[i], u_sys.tx_q[i])
   endtask

   task automatic do_load(input logic [31:0] addr, input int n, stop, input logic [7:0] adj,
                          input sbl_pkg::sbl_err_e err);
      logic [7:0] sum;
      int         cyc;
      command(addr, 32'(n), 8'h00, 150, 1'b1);
      for (cyc = 0; cyc < 200 && u_sys.tx_q.size() < 3; cyc++) @(negedge clk_in);
      sum = 8'h00;
      for (int i = 0; i < stop; i++) begin
         sum = sum + dval(i);
         send(dval(i), 1'b0);
      end
      if (stop == n) send(8'h00 - sum + adj, 1'b0);
      wait_done(cyc);
      if (stop != n) `CHK("late", 1'b1, cyc > TMO - 16 && cyc < TMO + 40)
      `CHK("err", err, result_out.err)
      `CHK("writes", stop, u_sys.wr_addr_q.size())
      foreach (u_sys.wr_addr_q[i]) begin
         `CHK("waddr", addr + 32'(i), u_sys.wr_addr_q[i])
         `CHK("wdata", dval(i), u_sys.wr_data_q[i])
      end
      repeat (3) exp_q.push_back(sbl_pkg::CHR_PROMPT);
      if (err != sbl_pkg::SBL_ERR_NONE) exp_q.push_back(sbl_pkg::CHR_QUERY);
      chk_tx();
   endtask

   task automatic t_load_ok();
      do_load(32'h0000_0100, 24, 24, 8'h00, sbl_pkg::SBL_ERR_NONE);
   endtask

   task automatic t_load_bad_sum();
      do_load(32'h0000_0FFE, 8, 8, 8'h01, sbl_pkg::SBL_ERR_DATA);
   endtask

   task automatic t_load_mem_err();
      u_sys.err_arm = 1'b1;
      do_load(32'h0000_2000, 6, 6, 8'h00, sbl_pkg::SBL_ERR_DATA);
      u_sys.err_arm = 1'b0;
   endtask

   task automatic t_load_stall();
      do_load(32'h0000_0300, 4, 2, 8'h00, sbl_pkg::SBL_ERR_TIMEOUT);
   endtask

   task automatic t_cmd_fail(input logic [7:0] adj, input bit ck, input sbl_pkg::sbl_err_e err);
      int cyc;
      command(32'h0000_0100, 32'h0000_0004, adj, 0, ck);
      wait_done(cyc);
      if (!ck) `CHK("late", 1'b1, cyc > TMO - 16 && cyc < TMO + 40)
      `CHK("err", err, result_out.err)
      `CHK("writes", 0, u_sys.wr_addr_q.size())
      exp_q.push_back(sbl_pkg::CHR_QUERY);
      chk_tx();
   endtask

   task automatic t_unload();
      logic [7:0] b, sum;
      int         cyc;
      command(32'h0000_02FE, 32'h8000_0005, 8'h00, 0, 1'b1);
      wait_done(cyc);
      `CHK("err", sbl_pkg::SBL_ERR_NONE, result_out.err)
      `CHK("writes", 0, u_sys.wr_addr_q.size())
      repeat (3) exp_q.push_back(sbl_pkg::CHR_PROMPT);
      sum = 8'h00;
      for (int i = 0; i < 5; i++) begin
         b = 8'(32'h2FE + i) ^ 8'hA5;
         sum = sum + b;
         exp_q.push_back(b);
      end
      exp_q.push_back(8'h00 - sum);
      chk_tx();
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // reset, then every scenario in turn
   initial begin
      srst_in     = 1'b1;
      ce_in       = 1'b1;
      start_in    = 1'b0;
      rx_valid_in = 1'b0;
      rx_data_in  = 8'h00;
      line_err_in = 1'b0;
      repeat (12) @(posedge clk_in);
      srst_in <= 1'b0;
      @(negedge clk_in);
      `CHK("busy", 1'b0, busy_out)
      `CHK("flow", 1'b1, flow_en_out)
      t_load_ok();
      t_unload();
      t_load_bad_sum();
      t_load_mem_err();
      t_cmd_fail(8'h01, 1'b1, sbl_pkg::SBL_ERR_CMD);
      t_cmd_fail(8'h00, 1'b0, sbl_pkg::SBL_ERR_TIMEOUT);
      t_load_stall();
      end_of_test();
   end
endmodule // sbl_top_tb
`default_nettype wire
